// [verilog/card_cmd_pkg.sv]
// Constants and carrier types shared by the card command decoder files.
// Assumes one 20 MHz clock and commands already deframed and CRC-checked.
package card_cmd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Command indices
   localparam logic [5:0] CMD_STOP   = 6'h0c;
   localparam logic [5:0] CMD_STATUS = 6'h0d;
   localparam logic [5:0] CMD_SLEEP  = 6'h0f;
   localparam logic [5:0] CMD_BLKLEN = 6'h10;
   localparam logic [5:0] CMD_RD_ONE = 6'h11;
   localparam logic [5:0] CMD_RD_MUL = 6'h12;
   localparam logic [5:0] CMD_TUNE   = 6'h13;
   localparam logic [5:0] CMD_SPEED  = 6'h14;
   localparam logic [5:0] CMD_BLKCNT = 6'h17;

   ////////////////////////////////////////////////////////////////////////////
   // Lengths and status layout
   localparam logic [9:0]  BLK_DEF     = 10'h200;
   localparam logic [31:0] BLK_MAX     = 32'h0000_0200;
   localparam logic [9:0]  TUNE_LEN    = 10'h040;
   localparam int          ST_ERR_BIT  = 29;
   localparam logic [3:0]  ST_TRAN     = 4'h4;
   localparam logic [3:0]  ST_DATA     = 4'h5;

   ////////////////////////////////////////////////////////////////////////////
   // Busy time after a busy-type response
   localparam int CLK_MHZ  = 20;
   localparam int BUSY_NS  = 500;
   localparam int BUSY_CYC = (BUSY_NS * CLK_MHZ + 999) / 1000;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      RSP_NONE = 2'b00,
      RSP_R1   = 2'b01,
      RSP_R1B  = 2'b10
   } rkind_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_BUSY = 2'b10,
      ST_OFF  = 2'b11
   } state_e;

   typedef struct packed {
      logic [5:0]  index;
      logic [31:0] arg;
   } cmd_s;

   typedef struct packed {
      rkind_e      kind;
      logic [31:0] status;
   } resp_s;

   typedef struct packed {
      logic [7:0] data;
      logic       first;
      logic       last;
   } byte_s;

endpackage

// [verilog/byte_buf2.sv]
// Two-entry byte buffer between the block streamer and the data pins.
// Assumes the drain side may stall at any time; ready and valid are flops.
module byte_buf2 (
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic               in_valid,
   input  wire card_cmd_pkg::byte_s in_data,
   output logic                    in_ready,
   output logic                    out_valid,
   output card_cmd_pkg::byte_s     out_data,
   input  wire logic               out_ready
);

   card_cmd_pkg::byte_s d1_r;
   logic [1:0]          cnt_r;
   logic [1:0]          cnt_nxt;
   wire                 push = in_valid & in_ready;
   wire                 pop  = out_valid & out_ready;

   // Head and second slot loading
   assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   wire load_d0 = (pop & cnt_r == 2'd2) | (push & (cnt_r == 2'd0 | (pop & cnt_r == 2'd1)));
   wire load_d1 = push & ((cnt_r == 2'd1 & ~pop) | (cnt_r == 2'd2 & pop));
   wire card_cmd_pkg::byte_s d0_nxt = (cnt_r == 2'd2) ? d1_r : in_data;

   // Storage and flags
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r     <= 2'd0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
         out_data  <= '0;
         d1_r      <= '0;
      end else begin
         cnt_r     <= cnt_nxt;
         in_ready  <= (cnt_nxt != 2'd2);
         out_valid <= (cnt_nxt != 2'd0);
         if (load_d0) begin
            out_data <= d0_nxt;
         end
         if (load_d1) begin
            d1_r <= in_data;
         end
      end
   end

endmodule

// [verilog/blk_streamer.sv]
// Counts read bytes into blocks and blocks into a transfer.
// Assumes the memory only offers bytes while active is high.
module blk_streamer (
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic                start,
   input  wire logic                abort,
   input  wire logic [9:0]          len,
   input  wire logic [31:0]         limit,
   input  wire logic                take,
   input  wire logic [7:0]          in_data,
   output card_cmd_pkg::byte_s      out_byte,
   output logic                     active,
   output logic                     done
);

   logic [9:0]  byte_r;
   logic [9:0]  len_r;
   logic [31:0] blk_r;
   logic [31:0] limit_r;

   // Block and transfer boundaries; limit zero streams until stopped
   wire last_byte = (byte_r == len_r - 10'd1);
   wire last_blk  = (limit_r != 32'h0) & (blk_r == limit_r - 32'h1);
   wire finish    = take & last_byte & last_blk;
   assign out_byte = '{data: in_data, first: (byte_r == 10'h0), last: last_byte};

   // Counters
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         byte_r  <= 10'h0;
         len_r   <= 10'h0;
         blk_r   <= 32'h0;
         limit_r <= 32'h0;
         active  <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= finish | (abort & active);
         if (start) begin
            byte_r  <= 10'h0;
            blk_r   <= 32'h0;
            len_r   <= len;
            limit_r <= limit;
            active  <= 1'b1;
         end else if (abort | finish) begin
            active <= 1'b0;
         end else if (take & last_byte) begin
            byte_r <= 10'h0;
            blk_r  <= blk_r + 32'h1;
         end else if (take) begin
            byte_r <= byte_r + 10'h1;
         end
      end
   end

endmodule

// [verilog/card_cmd_decoder.sv]
// Command decoder for basic and block-read commands of a memory card.
// Assumes commands arrive deframed, one per valid cycle, and the memory
// array streams bytes from the given address while mem_rd is high.
module card_cmd_decoder (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 cmd_valid,
   input  wire card_cmd_pkg::cmd_s   cmd,
   input  wire logic [15:0]          rca,
   input  wire logic                 ccs,
   input  wire logic                 partial_ok,
   output logic                      resp_valid,
   output card_cmd_pkg::resp_s       resp,
   output logic                      busy,
   output logic                      inactive,
   output logic [9:0]                lock_len,
   output logic [3:0]                spd_ctrl,
   output logic                      spd_strobe,
   output logic                      mem_start,
   output logic [40:0]               mem_addr,
   output logic                      mem_tune,
   output logic                      mem_rd,
   input  wire logic                 mem_valid,
   input  wire logic [7:0]           mem_data,
   output logic                      mem_ready,
   output logic                      dout_valid,
   output card_cmd_pkg::byte_s       dout,
   input  wire logic                 dout_ready
);

   localparam int busy_hi = card_cmd_pkg::BUSY_CYC - 1;

   card_cmd_pkg::state_e st_r;
   card_cmd_pkg::state_e st_nxt;
   logic [9:0]           blk_len_r;
   logic [31:0]          blk_cnt_r;
   logic                 err_r;
   logic [7:0]           busy_cnt_r;
   logic                 str_done;
   card_cmd_pkg::byte_s  str_byte;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode; any other index, reserved 14/21/22 included, is ignored
   wire       live    = cmd_valid & (st_r != card_cmd_pkg::ST_OFF);
   wire       idle    = (st_r == card_cmd_pkg::ST_IDLE);
   wire [5:0] idx     = cmd.index;
   wire       rca_hit = (cmd.arg[31:16] == rca);
   // Stop is refused while the busy time of an earlier busy response runs
   wire c_stop   = live & (st_r != card_cmd_pkg::ST_BUSY) & (idx == card_cmd_pkg::CMD_STOP);
   wire c_status = live & (idx == card_cmd_pkg::CMD_STATUS) & rca_hit;
   wire c_sleep  = live & (idx == card_cmd_pkg::CMD_SLEEP) & rca_hit;
   wire c_len    = live & idle & (idx == card_cmd_pkg::CMD_BLKLEN);
   wire c_rd_one = live & idle & (idx == card_cmd_pkg::CMD_RD_ONE);
   wire c_rd_mul = live & idle & (idx == card_cmd_pkg::CMD_RD_MUL);
   wire c_tune   = live & idle & (idx == card_cmd_pkg::CMD_TUNE);
   wire c_speed  = live & idle & (idx == card_cmd_pkg::CMD_SPEED);
   wire c_cnt    = live & idle & (idx == card_cmd_pkg::CMD_BLKCNT);
   wire rd_start = c_rd_one | c_rd_mul | c_tune;
   wire answers  = c_stop | c_status | c_len | rd_start | c_speed | c_cnt;
   wire is_r1b   = c_stop | c_speed;

   ////////////////////////////////////////////////////////////////////////////
   // Block length checks and effective read geometry
   wire len_big = c_len & (cmd.arg > card_cmd_pkg::BLK_MAX);
   wire len_ok  = c_len & ~len_big;
   wire std_len = ~ccs & partial_ok;
   wire [9:0] rd_len = std_len ? blk_len_r : card_cmd_pkg::BLK_DEF;
   wire [9:0] eff_len = c_tune ? card_cmd_pkg::TUNE_LEN : rd_len;
   wire [31:0] eff_lim = c_rd_mul ? blk_cnt_r : 32'h1;
   wire [40:0] eff_addr = ccs ? {cmd.arg, 9'h0} : {9'h0, cmd.arg};

   ////////////////////////////////////////////////////////////////////////////
   // Status word; length error is reported then cleared by a status query
   wire [3:0] cur_st = (st_r == card_cmd_pkg::ST_READ) ? card_cmd_pkg::ST_DATA : card_cmd_pkg::ST_TRAN;
   wire err_now = err_r | len_big;
   wire [31:0] status_word = {2'b00, err_now, 16'h0, cur_st, 1'b1, 8'h00};
   wire err_nxt = len_big | (err_r & ~c_status);

   ////////////////////////////////////////////////////////////////////////////
   // State sequencing
   wire busy_end = (busy_cnt_r == 8'h0);
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         card_cmd_pkg::ST_IDLE: begin
            if (c_sleep) begin
               st_nxt = card_cmd_pkg::ST_OFF;
            end else if (c_speed | c_stop) begin
               st_nxt = card_cmd_pkg::ST_BUSY;
            end else if (rd_start) begin
               st_nxt = card_cmd_pkg::ST_READ;
            end
         end
         card_cmd_pkg::ST_READ: begin
            if (c_sleep) begin
               st_nxt = card_cmd_pkg::ST_OFF;
            end else if (c_stop) begin
               st_nxt = card_cmd_pkg::ST_BUSY;
            end else if (str_done) begin
               st_nxt = card_cmd_pkg::ST_IDLE;
            end
         end
         card_cmd_pkg::ST_BUSY: begin
            if (busy_end) begin
               st_nxt = card_cmd_pkg::ST_IDLE;
            end
         end
         card_cmd_pkg::ST_OFF: begin
            st_nxt = card_cmd_pkg::ST_OFF;
         end
         default: begin
            st_nxt = card_cmd_pkg::ST_IDLE;
         end
      endcase
   end

   wire enter_busy = (st_nxt == card_cmd_pkg::ST_BUSY) & (st_r != card_cmd_pkg::ST_BUSY);
   wire [7:0] busy_cnt_nxt = enter_busy ? 8'(busy_hi) : (busy_end ? 8'h0 : busy_cnt_r - 8'h1);

   // State, busy timer and stored settings
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r       <= card_cmd_pkg::ST_IDLE;
         busy_cnt_r <= 8'h0;
         blk_len_r  <= card_cmd_pkg::BLK_DEF;
         blk_cnt_r  <= 32'h0;
         err_r      <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         busy_cnt_r <= busy_cnt_nxt;
         err_r      <= err_nxt;
         if (len_ok) begin
            blk_len_r <= cmd.arg[9:0];
         end
         if (c_cnt) begin
            blk_cnt_r <= cmd.arg;
         end else if (c_rd_mul) begin
            blk_cnt_r <= 32'h0;
         end
      end
   end

   // Registered outputs: response, busy, settings and memory request
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         resp_valid <= 1'b0;
         resp       <= '0;
         busy       <= 1'b0;
         inactive   <= 1'b0;
         lock_len   <= card_cmd_pkg::BLK_DEF;
         spd_ctrl   <= 4'h0;
         spd_strobe <= 1'b0;
         mem_start  <= 1'b0;
         mem_addr   <= 41'h0;
         mem_tune   <= 1'b0;
      end else begin
         resp_valid <= answers;
         resp       <= '{kind: is_r1b ? card_cmd_pkg::RSP_R1B : (answers ? card_cmd_pkg::RSP_R1
                                                                       : card_cmd_pkg::RSP_NONE),
                         status: status_word};
         busy       <= (st_nxt == card_cmd_pkg::ST_BUSY);
         inactive   <= (st_nxt == card_cmd_pkg::ST_OFF);
         spd_strobe <= c_speed;
         mem_start  <= rd_start;
         if (len_ok) begin
            lock_len <= cmd.arg[9:0];
         end
         if (c_speed) begin
            spd_ctrl <= cmd.arg[31:28];
         end
         if (rd_start) begin
            mem_addr <= eff_addr;
            mem_tune <= c_tune;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data path: streamer then two-entry buffer
   wire take = mem_valid & mem_ready & mem_rd;

   blk_streamer u_str (
      .clk      (clk),
      .nrst     (nrst),
      .start    (rd_start),
      .abort    (c_stop | c_sleep),
      .len      (eff_len),
      .limit    (eff_lim),
      .take     (take),
      .in_data  (mem_data),
      .out_byte (str_byte),
      .active   (mem_rd),
      .done     (str_done)
   );

   byte_buf2 u_buf (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (take),
      .in_data   (str_byte),
      .in_ready  (mem_ready),
      .out_valid (dout_valid),
      .out_data  (dout),
      .out_ready (dout_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   len_error_a: assert property (@(posedge clk) disable iff (!nrst)
      len_big |=> err_r && resp.status[card_cmd_pkg::ST_ERR_BIT]) else $error("length error not flagged");
   len_keep_a: assert property (@(posedge clk) disable iff (!nrst)
      c_len |=> blk_len_r == ($past(len_big) ? $past(blk_len_r) : $past(cmd.arg[9:0])))
      else $error("block length update wrong");
   hc_len_a: assert property (@(posedge clk) disable iff (!nrst)
      (c_rd_one | c_rd_mul) && ccs |-> eff_len == 10'h200) else $error("high capacity length not 512");
   stop_end_a: assert property (@(posedge clk) disable iff (!nrst)
      c_stop && mem_rd |=> !mem_rd && busy && resp.kind == card_cmd_pkg::RSP_R1B)
      else $error("stop did not end transfer");
   busy_time_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(busy) |-> ##busy_hi busy ##1 !busy) else $error("busy length wrong");
   status_ans_a: assert property (@(posedge clk) disable iff (!nrst)
      c_status |=> resp_valid && resp.status == $past(status_word)) else $error("status not returned");
   off_silent_a: assert property (@(posedge clk) disable iff (!nrst)
      c_sleep |=> inactive ##1 (inactive && !resp_valid)[*2]) else $error("inactive card answered");
   hc_addr_a: assert property (@(posedge clk) disable iff (!nrst)
      rd_start && ccs && !c_tune |=> mem_addr == {$past(cmd.arg), 9'h0}) else $error("block address not scaled");
   cnt_store_a: assert property (@(posedge clk) disable iff (!nrst)
      c_cnt |=> blk_cnt_r == $past(cmd.arg)) else $error("block count not stored");
   tune_start_a: assert property (@(posedge clk) disable iff (!nrst)
      c_tune |=> mem_tune && mem_rd && resp_valid && resp.kind == card_cmd_pkg::RSP_R1)
      else $error("tuning read not started");
   speed_code_a: assert property (@(posedge clk) disable iff (!nrst)
      c_speed |=> spd_ctrl == $past(cmd.arg[31:28]) && spd_strobe) else $error("speed code not taken");

   rsvd_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
      cmd_valid && (idx == 6'h0e || idx == 6'h15 || idx == 6'h16) |=> !resp_valid)
      else $error("reserved index answered");
   cnt_used_a: assert property (@(posedge clk) disable iff (!nrst)
      c_rd_mul |=> blk_cnt_r == 32'h0) else $error("block count not consumed");
   lock_follow_a: assert property (@(posedge clk) disable iff (!nrst)
      len_ok |=> lock_len == $past(cmd.arg[9:0])) else $error("lock length not updated");
   status_addr_a: assert property (@(posedge clk) disable iff (!nrst)
      live && idx == card_cmd_pkg::CMD_STATUS && !rca_hit |=> !resp_valid)
      else $error("status answered for other address");
   busy_stop_a: assert property (@(posedge clk) disable iff (!nrst)
      st_r == card_cmd_pkg::ST_BUSY && cmd_valid && idx == card_cmd_pkg::CMD_STOP |=> !resp_valid)
      else $error("stop answered while busy");

   // Main scenarios
   single_done_c: cover property (@(posedge clk) disable iff (!nrst) c_rd_one ##[1:1000] str_done);
   err_report_c: cover property (@(posedge clk) disable iff (!nrst) c_status && err_r);
   stop_mid_c: cover property (@(posedge clk) disable iff (!nrst) c_rd_mul ##[1:1000] c_stop);
   tune_done_c: cover property (@(posedge clk) disable iff (!nrst) c_tune ##[1:300] str_done);

endmodule

// [tb/mem_model.sv]
// Memory array model that feeds the decoder's read stream.
// Assumes a byte is taken at clk when mem_valid, mem_ready and mem_rd are high.
module mem_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        slow,
   input  wire logic        mem_start,
   input  wire logic [40:0] mem_addr,
   input  wire logic        mem_rd,
   input  wire logic        mem_ready,
   output logic             mem_valid,
   output logic [7:0]       mem_data
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] base_r;
   logic [7:0] cnt_r;
   logic [1:0] phase_r;
   logic [7:0] cur_base;
   logic [7:0] cur_cnt;
   logic       take;

   ////////////////////////////////////////////////////////////////////////////
   // Byte pattern follows the start address, so a wrong address shows up
   assign cur_base  = mem_start ? mem_addr[7:0] : base_r;
   assign cur_cnt   = mem_start ? 8'h00 : cnt_r;
   assign take      = mem_valid & mem_ready & mem_rd;
   // Slow mode withholds a byte every fourth cycle; idle data is inverted
   assign mem_valid = mem_rd & ~(slow & (phase_r == 2'h0));
   assign mem_data  = mem_valid ? cur_base + cur_cnt : ~(cur_base + cur_cnt);

   // Address and count of the current transfer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         base_r  <= 8'h00;
         cnt_r   <= 8'h00;
         phase_r <= 2'h0;
      end else begin
         base_r  <= cur_base;
         cnt_r   <= cur_cnt + {7'h00, take};
         phase_r <= phase_r + 2'h1;
      end
   end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the card command decoder.
// Assumes the design package is compiled first and the memory model beside it.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [5:0]  idx;
      logic [31:0] arg;
      logic        ccs;
      logic        pok;
      logic [1:0]  kind;
      logic [15:0] nb;
      logic [7:0]  nblk;
      logic [40:0] addr;
      logic        chk;
   } row_s;

   logic                 clk, nrst, cmd_valid, ccs, partial_ok, resp_valid, busy, inactive;
   logic                 spd_strobe, mem_start, mem_tune, mem_rd, mem_valid, mem_ready;
   logic                 dout_valid, dout_ready, hold, slow, chk_data;
   card_cmd_pkg::cmd_s   cmd;
   card_cmd_pkg::resp_s  resp;
   card_cmd_pkg::byte_s  dout;
   logic [15:0]          rca;
   logic [9:0]           lock_len;
   logic [3:0]           spd_ctrl;
   logic [40:0]          mem_addr;
   logic [7:0]           mem_data, exp_base;
   logic [1:0]           rp;
   int                   mismatches, n_tests, nb, nl, nf, cycles, n;
   row_s                 rows [10];

   card_cmd_decoder dut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd), .rca(rca), .ccs(ccs),
      .partial_ok(partial_ok), .resp_valid(resp_valid), .resp(resp), .busy(busy), .inactive(inactive),
      .lock_len(lock_len), .spd_ctrl(spd_ctrl), .spd_strobe(spd_strobe), .mem_start(mem_start),
      .mem_addr(mem_addr), .mem_tune(mem_tune), .mem_rd(mem_rd), .mem_valid(mem_valid), .mem_data(mem_data),
      .mem_ready(mem_ready), .dout_valid(dout_valid), .dout(dout), .dout_ready(dout_ready));

   mem_model u_mem (.clk(clk), .nrst(nrst), .slow(slow), .mem_start(mem_start), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_ready(mem_ready), .mem_valid(mem_valid), .mem_data(mem_data));

   ////////////////////////////////////////////////////////////////////////////
   // Clock, receiver stall pattern and run limit
   always #25 clk = ~clk;

   always @(posedge clk) begin
      rp         <= rp + 2'h1;
      dout_ready <= ~hold & (rp != 2'h0);
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         report_and_stop();
      end
   end

   // Received bytes and block boundaries
   always @(posedge clk) begin
      if (dout_valid === 1'b1 && dout_ready === 1'b1) begin
         if (chk_data) check(dout.data, 8'(exp_base + nb), "read byte");
         nb++;
         if (dout.last === 1'b1) nl++;
         if (dout.first === 1'b1) nf++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Waits out busy, gives one command, looks at the answer in the next cycle
   task automatic send(input logic [5:0] idx, input logic [31:0] arg, input logic [1:0] kind);
      for (int k = 0; k < 50 && busy === 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd       <= {idx, arg};
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      check(resp_valid, kind != 2'h0, "response present");
      if (kind != 2'h0) check(resp.kind, kind, "response kind");
   endtask

   task automatic do_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1;
      check(lock_len, card_cmd_pkg::BLK_DEF, "default length");
      check({busy, inactive, resp_valid}, 3'h0, "idle after reset");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 1'b0; nrst = 1'b0; cmd_valid = 1'b0; cmd = '0; rca = 16'h1234; ccs = 1'b0;
      partial_ok = 1'b1; hold = 1'b0; slow = 1'b1; dout_ready = 1'b0; rp = 2'h0; chk_data = 1'b0;
      exp_base = 8'h00; mismatches = 0; n_tests = 0; nb = 0; nl = 0; nf = 0; cycles = 0;
      rows = '{
         '{6'h10, 32'h0000_0040, 1'b0, 1'b1, 2'h1, 16'h0000, 8'h00, 41'h0, 1'b0},
         '{6'h11, 32'h0000_0100, 1'b0, 1'b1, 2'h1, 16'h0040, 8'h01, 41'h100, 1'b1},
         '{6'h11, 32'h0000_0100, 1'b0, 1'b0, 2'h1, 16'h0200, 8'h01, 41'h100, 1'b1},
         '{6'h11, 32'h0000_0003, 1'b1, 1'b1, 2'h1, 16'h0200, 8'h01, 41'h600, 1'b1},
         '{6'h17, 32'h0000_0002, 1'b0, 1'b1, 2'h1, 16'h0000, 8'h00, 41'h0, 1'b0},
         '{6'h12, 32'h0000_0020, 1'b0, 1'b1, 2'h1, 16'h0080, 8'h02, 41'h20, 1'b1},
         '{6'h13, 32'h0000_0000, 1'b0, 1'b1, 2'h1, 16'h0040, 8'h01, 41'h0, 1'b0},
         '{6'h0e, 32'h0000_0000, 1'b0, 1'b1, 2'h0, 16'h0000, 8'h00, 41'h0, 1'b0},
         '{6'h15, 32'h0000_0000, 1'b0, 1'b1, 2'h0, 16'h0000, 8'h00, 41'h0, 1'b0},
         '{6'h16, 32'h0000_0000, 1'b0, 1'b1, 2'h0, 16'h0000, 8'h00, 41'h0, 1'b0}};
      do_reset();
      // Table of ordinary commands
      foreach (rows[i]) begin
         ccs = rows[i].ccs;
         partial_ok = rows[i].pok;
         nb = 0; nl = 0; nf = 0;
         exp_base = rows[i].addr[7:0];
         chk_data = rows[i].chk;
         send(rows[i].idx, rows[i].arg, rows[i].kind);
         if (rows[i].chk) check(mem_addr, rows[i].addr, "start address");
         if (rows[i].nb != 16'h0) check({mem_start, mem_tune}, {1'b1, rows[i].idx == 6'h13}, "read start");
         for (int k = 0; k < 3000 && nb < rows[i].nb; k++) @(posedge clk);
         repeat (6) @(posedge clk);
         #1;
         check(nb, rows[i].nb, "byte count");
         check({nl, nf}, {2{32'(rows[i].nblk)}}, "block marks");
      end
      // Length above the limit: error flag, old length kept
      send(card_cmd_pkg::CMD_BLKLEN, 32'h0000_0201, 2'h1);
      check(resp.status[card_cmd_pkg::ST_ERR_BIT], 1'b1, "length error");
      check(lock_len, 10'h040, "lock length");
      send(card_cmd_pkg::CMD_STATUS, {rca, 16'h0000}, 2'h1);
      check({resp.status[card_cmd_pkg::ST_ERR_BIT], resp.status[12:9]}, {1'b1, card_cmd_pkg::ST_TRAN}, "status");
      send(card_cmd_pkg::CMD_STATUS, {~rca, 16'h0000}, 2'h0);
      // Speed class code
      send(card_cmd_pkg::CMD_SPEED, 32'h3000_0000, 2'h2);
      check({spd_strobe, spd_ctrl}, 5'h13, "speed code");
      // Receiver stalls until the buffer refuses, then stop in mid-read
      nb = 0; exp_base = 8'h00; chk_data = 1'b1; hold = 1'b1;
      send(card_cmd_pkg::CMD_RD_MUL, 32'h0000_0000, 2'h1);
      repeat (12) @(posedge clk);
      #1;
      check({mem_ready, dout_valid}, 2'h1, "buffer full");
      hold = 1'b0;
      repeat (40) @(posedge clk);
      send(card_cmd_pkg::CMD_STOP, 32'h0000_0000, 2'h2);
      check(mem_rd, 1'b0, "stream ended");
      n = 0;
      repeat (15) begin
         if (busy === 1'b1) n++;
         @(posedge clk);
         #1;
      end
      check(n, card_cmd_pkg::BUSY_CYC, "busy length");
      check(dout_valid, 1'b0, "buffer drained");
      // Deactivation by address, silent afterwards
      send(card_cmd_pkg::CMD_SLEEP, {~rca, 16'h0000}, 2'h0);
      check(inactive, 1'b0, "other address");
      send(card_cmd_pkg::CMD_SLEEP, {rca, 16'h0000}, 2'h0);
      @(posedge clk);
      #1;
      check(inactive, 1'b1, "inactive");
      send(card_cmd_pkg::CMD_STATUS, {rca, 16'h0000}, 2'h0);
      // Second reset in mid-run
      do_reset();
      report_and_stop();
   end
endmodule
